//--- jtx_pkg.sv
/*
 Constants shared by both ends of the serial converter link:
 control characters, register offsets, field positions, reset values.
 Assumes octet-wide symbols per lane ahead of an external 8b/10b encoder.
*/
package jtx_pkg;
  localparam int unsigned LANES_DEF = 3;
  localparam int unsigned ILA_MFRAMES = 4;
  // Control characters, carried with the k flag set
  localparam logic [7:0] K_COMMA = 8'hbc;
  localparam logic [7:0] K_MF_START = 8'h1c;
  localparam logic [7:0] K_MF_END = 8'h7c;
  localparam logic [7:0] K_CFG_MARK = 8'h9c;
  localparam logic [7:0] K_FR_END = 8'hfc;
  // Device register offsets
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_FRAME = 8'h70;
  localparam logic [7:0] REG_MFRAME = 8'h71;
  localparam logic [7:0] REG_LINK = 8'h72;
  localparam logic [7:0] REG_SYNCPIN = 8'h77;
  localparam logic [7:0] REG_TEST = 8'hc0;
  // Reset values; frame and multiframe lengths stored as value minus one
  localparam logic [7:0] FRAME_RST = 8'h01;
  localparam logic [7:0] MFRAME_RST = 8'h08;
  localparam logic [7:0] LINK_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  // Link control field positions
  localparam int unsigned LINK_SCR_EN = 0;
  localparam int unsigned LINK_LSYNC = 1;
  // Test control field positions
  localparam int unsigned TEST_EN = 7;
  localparam int unsigned TEST_LINK = 4;
  localparam int unsigned TEST_KIND = 0;
  localparam logic [6:0] PRBS_SEED = 7'h7f;
  localparam logic [14:0] SCR_SEED = 15'h7fff;
  localparam logic [13:0] TP_FIXED = 14'h2aaa;
  // Lane rate in ten-thousandths of the sample clock per mode
  localparam int unsigned RATE_EFF3_X1E4 = 58333;
  localparam int unsigned RATE_EFF2_X1E4 = 87500;
  localparam int unsigned RATE_SIMPLE_X1E4 = 100000;
  localparam int unsigned TAIL_BITS = 2;
  // Controller register offsets on the AXI side
  localparam logic [3:0] AXI_CTRL = 4'h0;
  localparam logic [3:0] AXI_STATUS = 4'h4;
  localparam logic [3:0] AXI_CFG = 4'h8;
  localparam logic [3:0] AXI_CFG_RD = 4'hc;
  localparam int unsigned CGS_COUNT = 4;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
endpackage

//--- jtx_link_if.sv
/*
 Link between the transmitter and the receiver end: per lane octet
 and control flag, the active-low sync request, and a byte-wide
 configuration port into the transmitter registers.
*/
`timescale 1ns/1ps
interface jtx_link_if #(
  parameter int unsigned LANES = 3
);
  logic                        sync_n;
  logic [LANES-1:0][7:0]       lane_data;
  logic [LANES-1:0]            lane_k;
  logic                        cfg_we;
  logic [7:0]                  cfg_addr;
  logic [7:0]                  cfg_wdata;
  logic [7:0]                  cfg_rdata;
  modport dev (input sync_n, cfg_we, cfg_addr, cfg_wdata,
               output lane_data, lane_k, cfg_rdata);
  modport rcv (output sync_n, cfg_we, cfg_addr, cfg_wdata,
               input lane_data, lane_k, cfg_rdata);
endinterface

//--- jtx_tx_end.sv
/*
 Transmitter end: sync handling, alignment sequence, octet packing,
 scrambler, end-of-frame substitution and test patterns.
 Assumes one octet per lane per clock into an external 8b/10b encoder,
 and a sample that is valid on every clock.
*/
`timescale 1ns/1ps
module jtx_tx_end #(
  parameter int unsigned LANES = jtx_pkg::LANES_DEF
) (
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [13:0] SAMPLE_IN,
  output logic             DIVRST_OUT,
  jtx_link_if.dev          link
);
  if (LANES < 1 || LANES > 4) $error("jtx_tx_end: LANES must be 1 to 4");

  typedef enum logic [1:0] {
    ST_CGS  = 2'b00,
    ST_ILA  = 2'b01,
    ST_DATA = 2'b10
  } jtx_st_e;

  typedef struct packed {
    jtx_st_e                 st;
    logic [7:0]              oct;
    logic [7:0]              frm;
    logic [7:0]              pos;
    logic [1:0]              mf;
    logic [LANES-1:0][14:0]  scr;
    logic [LANES-1:0][7:0]   last;
    logic [LANES-1:0][7:0]   dout;
    logic [LANES-1:0]        kout;
    logic [13:0]             ramp;
    logic [6:0]              prbs;
    logic [7:0]              f_enc;
    logic [7:0]              k_enc;
    logic [7:0]              lctl;
    logic [7:0]              spin;
    logic [7:0]              test;
    logic [7:0]              rdata;
    logic                    sync_q;
    logic                    divrst;
  } jtx_tx_s;

  jtx_tx_s r;
  jtx_tx_s next_r;

  // Self-synchronising 1 + x^14 + x^15, MSB first
  function automatic logic [22:0] scr_step(input logic [14:0] s, input logic [7:0] d);
    logic [14:0] t;
    logic [7:0]  o;
    logic        b;
    t = s;
    o = 8'h00;
    for (int j = 7; j >= 0; j--) begin
      b = d[j] ^ t[14] ^ t[13];
      t = {t[13:0], b};
      o[j] = b;
    end
    return {t, o};
  endfunction

  // x^7 + x^6 + 1, eight steps per octet
  function automatic logic [14:0] prbs_step(input logic [6:0] p);
    logic [6:0] t;
    logic [7:0] o;
    logic       b;
    t = p;
    o = 8'h00;
    for (int j = 7; j >= 0; j--) begin
      b = t[6] ^ t[5];
      t = {t[5:0], b};
      o[j] = b;
    end
    return {t, o};
  endfunction

  logic        eff_sync;
  logic        release_ev;
  logic        fr_end;
  logic        mf_end;
  logic [13:0] smp;
  logic [7:0]  d;
  logic [22:0] sres;
  logic [14:0] pres;
  logic        k;

  always_comb begin
    next_r = r;
    eff_sync = 1'b1;
    release_ev = 1'b0;
    fr_end = 1'b0;
    mf_end = 1'b0;
    smp = 14'h0000;
    d = 8'h00;
    sres = 23'h000000;
    pres = 15'h0000;
    k = 1'b0;
    next_r.divrst = 1'b0;

    if (link.cfg_we) begin
      case (link.cfg_addr)
        jtx_pkg::REG_FRAME:   next_r.f_enc = link.cfg_wdata;
        jtx_pkg::REG_MFRAME:  next_r.k_enc = link.cfg_wdata;
        jtx_pkg::REG_LINK:    next_r.lctl = link.cfg_wdata;
        jtx_pkg::REG_SYNCPIN: next_r.spin = link.cfg_wdata;
        jtx_pkg::REG_TEST:    next_r.test = link.cfg_wdata;
        default: ;
      endcase
    end
    case (link.cfg_addr)
      jtx_pkg::REG_STATUS:  next_r.rdata = {6'h00, r.st};
      jtx_pkg::REG_FRAME:   next_r.rdata = r.f_enc;
      jtx_pkg::REG_MFRAME:  next_r.rdata = r.k_enc;
      jtx_pkg::REG_LINK:    next_r.rdata = r.lctl;
      jtx_pkg::REG_SYNCPIN: next_r.rdata = r.spin;
      jtx_pkg::REG_TEST:    next_r.rdata = r.test;
      default:              next_r.rdata = 8'h00;
    endcase

    // Sync pin doubles as divider reset only when configured
    if (r.spin[0]) begin
      next_r.divrst = r.sync_q & ~link.sync_n;
    end else begin
      eff_sync = link.sync_n;
    end
    next_r.sync_q = link.sync_n;
    release_ev = eff_sync & ~r.sync_q & ~r.spin[0];

    fr_end = (r.oct == r.f_enc);
    mf_end = fr_end && (r.frm == r.k_enc);
    if (fr_end) begin
      next_r.oct = 8'h00;
      next_r.frm = mf_end ? 8'h00 : r.frm + 8'h01;
    end else begin
      next_r.oct = r.oct + 8'h01;
    end
    next_r.pos = mf_end ? 8'h00 : r.pos + 8'h01;

    // Pattern ramp counts once per frame
    if (fr_end) begin
      next_r.ramp = r.ramp + 14'h0001;
    end
    pres = prbs_step(r.prbs);
    next_r.prbs = pres[14:8];
    smp = SAMPLE_IN;
    if (r.test[jtx_pkg::TEST_EN] && !r.test[jtx_pkg::TEST_LINK]) begin
      smp = r.test[jtx_pkg::TEST_KIND] ? jtx_pkg::TP_FIXED : r.ramp;
    end

    for (int i = 0; i < LANES; i++) begin
      d = 8'h00;
      k = 1'b0;
      case (r.st)
        ST_CGS: begin
          d = jtx_pkg::K_COMMA;
          k = 1'b1;
        end
        ST_ILA: begin
          if (r.pos == 8'h00) begin
            d = jtx_pkg::K_MF_START;
            k = 1'b1;
          end else if (mf_end) begin
            d = jtx_pkg::K_MF_END;
            k = 1'b1;
          end else if (r.mf == 2'd1 && r.pos == 8'h01) begin
            d = jtx_pkg::K_CFG_MARK;
            k = 1'b1;
          end else if (r.mf == 2'd1 && r.pos < 8'h06) begin
            case (r.pos[2:0])
              3'd2:    d = 8'(i);
              3'd3:    d = r.f_enc;
              3'd4:    d = r.k_enc;
              default: d = {r.lctl[1:0], 6'(LANES - 1)};
            endcase
          end else begin
            d = r.pos;
          end
          sres = scr_step(r.scr[i], d);
          next_r.scr[i] = sres[22:8];
        end
        ST_DATA: begin
          // Even octets carry the high bits, odd ones the rest plus tail
          d = r.oct[0] ? {smp[5:0], 2'b00} : smp[13:6];
          sres = scr_step(r.scr[i], d);
          next_r.scr[i] = sres[22:8];
          if (r.lctl[jtx_pkg::LINK_SCR_EN]) begin
            d = sres[7:0];
          end
          if (r.test[jtx_pkg::TEST_EN] && r.test[jtx_pkg::TEST_LINK]) begin
            d = r.test[jtx_pkg::TEST_KIND] ? jtx_pkg::K_COMMA : pres[7:0];
            k = r.test[jtx_pkg::TEST_KIND];
          end else if (fr_end) begin
            next_r.last[i] = d;
            if (d == r.last[i]) begin
              k = 1'b1;
              d = (mf_end && r.lctl[jtx_pkg::LINK_LSYNC]) ? jtx_pkg::K_MF_END
                                                           : jtx_pkg::K_FR_END;
            end
          end
        end
        default: begin
          d = jtx_pkg::K_COMMA;
          k = 1'b1;
        end
      endcase
      next_r.dout[i] = d;
      next_r.kout[i] = k;
    end

    case (r.st)
      ST_CGS: begin
        if (release_ev) begin
          // Fixed pipeline from the release edge for multi-chip alignment
          next_r.st = ST_ILA;
          next_r.oct = 8'h00;
          next_r.frm = 8'h00;
          next_r.pos = 8'h00;
          next_r.mf = 2'd0;
          next_r.ramp = 14'h0000;
          next_r.prbs = jtx_pkg::PRBS_SEED;
          for (int i = 0; i < LANES; i++) begin
            next_r.scr[i] = jtx_pkg::SCR_SEED;
            next_r.last[i] = 8'h00;
          end
        end
      end
      ST_ILA: begin
        if (mf_end) begin
          next_r.mf = r.mf + 2'd1;
          if (r.mf == 2'(jtx_pkg::ILA_MFRAMES - 1)) begin
            next_r.st = ST_DATA;
          end
        end
      end
      ST_DATA: ;
      default: next_r.st = ST_CGS;
    endcase
    if (!eff_sync) begin
      next_r.st = ST_CGS;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      r <= '0;
      r.f_enc <= jtx_pkg::FRAME_RST;
      r.k_enc <= jtx_pkg::MFRAME_RST;
      r.lctl <= jtx_pkg::LINK_RST;
      r.test <= jtx_pkg::TEST_RST;
      r.prbs <= jtx_pkg::PRBS_SEED;
      r.sync_q <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign link.lane_data = r.dout;
  assign link.lane_k = r.kout;
  assign link.cfg_rdata = r.rdata;
  assign DIVRST_OUT = r.divrst;
endmodule

//--- jtx_rx_end.sv
/*
 Receiver end: drives the sync request from code group detection,
 tracks the alignment sequence, and exposes control and status plus a
 configuration path into the transmitter over an AXI4-Lite slave.
 Assumes lane octets arrive already decoded and aligned to the clock.
*/
`timescale 1ns/1ps
module jtx_rx_end #(
  parameter int unsigned LANES = jtx_pkg::LANES_DEF
) (
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [3:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [3:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  jtx_link_if.rcv          link
);
  if (LANES < 1 || LANES > 4) $error("jtx_rx_end: LANES must be 1 to 4");

  typedef enum logic [1:0] {
    RS_HOLD = 2'b00,
    RS_WAIT = 2'b01,
    RS_ILA  = 2'b10,
    RS_DATA = 2'b11
  } jtx_rs_e;

  typedef struct packed {
    jtx_rs_e     st;
    logic [2:0]  cnt;
    logic        aw_h;
    logic [3:0]  awaddr;
    logic        w_h;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        enable;
    logic [7:0]  cfg_addr;
    logic [7:0]  cfg_data;
    logic        cfg_we;
    logic        err;
  } jtx_rx_s;

  jtx_rx_s r;
  jtx_rx_s next_r;
  logic    all_comma;

  always_comb begin
    next_r = r;
    next_r.cfg_we = 1'b0;
    all_comma = (&link.lane_k);
    for (int i = 0; i < LANES; i++) begin
      if (link.lane_data[i] != jtx_pkg::K_COMMA) begin
        all_comma = 1'b0;
      end
    end

    if (S_AXI_AWVALID_IN && !r.aw_h && !r.bvalid) begin
      next_r.aw_h = 1'b1;
      next_r.awaddr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && !r.w_h && !r.bvalid) begin
      next_r.w_h = 1'b1;
      next_r.wdata = S_AXI_WDATA_IN;
      next_r.wstrb = S_AXI_WSTRB_IN;
    end
    if (r.aw_h && r.w_h) begin
      next_r.aw_h = 1'b0;
      next_r.w_h = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = jtx_pkg::RESP_OK;
      case (r.awaddr)
        jtx_pkg::AXI_CTRL: begin
          if (r.wstrb[0]) begin
            next_r.enable = r.wdata[0];
          end
          if (r.wstrb[0] && r.wdata[1]) begin
            next_r.err = 1'b0;
          end
        end
        jtx_pkg::AXI_CFG: begin
          if (r.wstrb[0]) begin
            next_r.cfg_data = r.wdata[7:0];
          end
          if (r.wstrb[1]) begin
            next_r.cfg_addr = r.wdata[15:8];
          end
          next_r.cfg_we = r.wstrb[0];
        end
        jtx_pkg::AXI_STATUS, jtx_pkg::AXI_CFG_RD: ;
        default: next_r.bresp = jtx_pkg::RESP_ERR;
      endcase
    end
    if (r.bvalid && S_AXI_BREADY_IN) begin
      next_r.bvalid = 1'b0;
    end

    if (S_AXI_ARVALID_IN && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = jtx_pkg::RESP_OK;
      case (S_AXI_ARADDR_IN)
        jtx_pkg::AXI_CTRL:   next_r.rdata = {31'h00000000, r.enable};
        jtx_pkg::AXI_STATUS: next_r.rdata = {27'h0000000, r.err, r.st, link.sync_n};
        jtx_pkg::AXI_CFG:    next_r.rdata = {16'h0000, r.cfg_addr, r.cfg_data};
        jtx_pkg::AXI_CFG_RD: next_r.rdata = {24'h000000, link.cfg_rdata};
        default: begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = jtx_pkg::RESP_ERR;
        end
      endcase
    end else if (r.rvalid && S_AXI_RREADY_IN) begin
      next_r.rvalid = 1'b0;
    end

    case (r.st)
      RS_HOLD: begin
        // Release only after a run of commas on every lane
        next_r.cnt = all_comma ? r.cnt + 3'd1 : 3'd0;
        if (all_comma && r.cnt == 3'(jtx_pkg::CGS_COUNT - 1)) begin
          next_r.st = RS_WAIT;
          next_r.cnt = 3'd0;
        end
      end
      RS_WAIT: begin
        if (link.lane_k[0] && link.lane_data[0] == jtx_pkg::K_MF_START) begin
          next_r.st = RS_ILA;
        end
      end
      RS_ILA: begin
        if (link.lane_k[0] && link.lane_data[0] == jtx_pkg::K_MF_END) begin
          next_r.cnt = r.cnt + 3'd1;
          if (r.cnt == 3'(jtx_pkg::ILA_MFRAMES - 1)) begin
            next_r.st = RS_DATA;
          end
        end
      end
      RS_DATA: begin
        // Commas in data mean the transmitter lost the link
        if (link.lane_k[0] && link.lane_data[0] == jtx_pkg::K_COMMA) begin
          next_r.err = 1'b1;
        end
      end
      default: next_r.st = RS_HOLD;
    endcase
    if (!r.enable) begin
      next_r.st = RS_HOLD;
      next_r.cnt = 3'd0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.sync_n = (r.st != RS_HOLD);
  assign link.cfg_we = r.cfg_we;
  assign link.cfg_addr = r.cfg_addr;
  assign link.cfg_wdata = r.cfg_data;
  assign S_AXI_AWREADY_OUT = !r.aw_h && !r.bvalid;
  assign S_AXI_WREADY_OUT = !r.w_h && !r.bvalid;
  assign S_AXI_BVALID_OUT = r.bvalid;
  assign S_AXI_BRESP_OUT = r.bresp;
  assign S_AXI_ARREADY_OUT = !r.rvalid;
  assign S_AXI_RVALID_OUT = r.rvalid;
  assign S_AXI_RDATA_OUT = r.rdata;
  assign S_AXI_RRESP_OUT = r.rresp;
endmodule

//--- jtx_link_checker.sv
/*
 Checker for the lanes and the sync request between the two ends.
 Assumes reset values F=2, K=9 and the markers carried on lane 0.
*/
`timescale 1ns/1ps
module jtx_link_checker #(
  parameter int unsigned LANES = 3
) (
  input wire logic                  CLK_IN,
  input wire logic                  SYS_RST_IN,
  input wire logic                  sync_n,
  input wire logic [LANES-1:0][7:0] lane_data,
  input wire logic [LANES-1:0]      lane_k
);
  logic [15:0] cnt;
  logic [7:0]  last_end;
  logic        have_end;
  logic        all_comma;
  logic        fe;
  logic        mfe;
  assign all_comma = (lane_k == '1) && (lane_data == {LANES{jtx_pkg::K_COMMA}});
  // Frame end: odd count in the data phase, which opens at count 74
  assign fe = (cnt >= 16'd74) && cnt[0];
  assign mfe = fe && ((cnt - 16'd74) % 16'd18 == 16'd17);
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || !sync_n) begin
      cnt <= '0;
      have_end <= 1'b0;
      last_end <= '0;
    end else begin
      cnt <= cnt + 16'd1;
      // Substituted octets keep the older value, which is the same
      if (fe && !lane_k[0]) begin
        last_end <= lane_data[0];
        have_end <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  a_comma_hold: assert property ((!sync_n) [*3] |=> all_comma)
    else $error("lanes not all comma while sync held");
  a_release_cgs: assert property ($rose(sync_n) |-> $past(all_comma, 2) &&
    $past(all_comma, 3) && $past(all_comma, 4))
    else $error("sync released without comma run");
  a_ila_start: assert property ($rose(sync_n) |->
    ##2 (lane_k[0] && lane_data[0] == jtx_pkg::K_MF_START))
    else $error("alignment start not two edges after release");
  a_mf_marks: assert property ($rose(sync_n) |->
    ##19 (lane_k[0] && lane_data[0] == jtx_pkg::K_MF_END)
    ##1 (lane_k[0] && lane_data[0] == jtx_pkg::K_MF_START))
    else $error("multiframe markers misplaced");
  a_cfg_params: assert property ($rose(sync_n) |->
    ##21 (lane_k[0] && lane_data[0] == jtx_pkg::K_CFG_MARK)
    ##2 (lane_data[0] == jtx_pkg::FRAME_RST) ##1 (lane_data[0] == jtx_pkg::MFRAME_RST))
    else $error("second multiframe parameters wrong");
  a_ila_end: assert property ($rose(sync_n) |->
    ##73 (lane_k[0] && lane_data[0] == jtx_pkg::K_MF_END))
    else $error("alignment sequence length wrong");
  a_data_start: assert property ($rose(sync_n) |-> ##74 (lane_k == '0))
    else $error("data does not follow alignment");
  a_frame_sub: assert property (fe && have_end && !lane_k[0] |->
    lane_data[0] != last_end)
    else $error("repeated frame end not substituted");
  a_ctrl_char: assert property (cnt >= 16'd74 && lane_k[0] |-> fe &&
    (lane_data[0] == jtx_pkg::K_FR_END || (mfe && lane_data[0] == jtx_pkg::K_MF_END)))
    else $error("bad control character in data");
endmodule

//--- tb.sv
/*
 Testbench: both ends joined by the link interface, driven over AXI4-Lite.
 Assumes reset values F=2, K=9; lane 0 is watched for the patterns.
*/
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst;
  logic [13:0] smp;
  logic        divrst;
  logic [3:0]  awaddr;
  logic [3:0]  araddr;
  logic [3:0]  wstrb;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] d;
  int          n_errors;
  int          cmp_count;
  int          aa;
  int          fc;
  int          mf;
  jtx_link_if #(.LANES(3)) link_i ();
  jtx_tx_end #(.LANES(3)) i_jtx_tx_end (.CLK_IN(clk), .SYS_RST_IN(rst), .SAMPLE_IN(smp),
    .DIVRST_OUT(divrst), .link(link_i));
  jtx_rx_end #(.LANES(3)) i_jtx_rx_end (.CLK_IN(clk), .SYS_RST_IN(rst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .link(link_i));
  jtx_link_checker #(.LANES(3)) i_jtx_link_checker (.CLK_IN(clk), .SYS_RST_IN(rst),
    .sync_n(link_i.sync_n), .lane_data(link_i.lane_data), .lane_k(link_i.lane_k));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;  // Lane rate is a system choice, not modelled
  end
  // Moving sample so the data path is never idle
  always @(posedge clk) smp <= smp + 14'h1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                        input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && t < 200);
    if (!bvalid) begin
      n_errors++;
      $display("CHECK FAILED bvalid expected 1 seen 0");
    end
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && t < 200);
    if (!rvalid) begin
      n_errors++;
      $display("CHECK FAILED rvalid expected 1 seen 0");
    end
    v = rdata;
    rready <= 1'b0;
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] v);
    axi_wr(jtx_pkg::AXI_CFG, {16'h0, a, v}, 4'b0011, jtx_pkg::RESP_OK);
  endtask
  task automatic dev_rd(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] r;
    axi_wr(jtx_pkg::AXI_CFG, {16'h0, a, 8'h0}, 4'b0010, jtx_pkg::RESP_OK);
    repeat (2) @(posedge clk);
    axi_rd(jtx_pkg::AXI_CFG_RD, r);
    v = r[7:0];
  endtask
  // Restart the link and wait for the data state
  task automatic relink(input logic [7:0] lctl);
    int t;
    axi_wr(jtx_pkg::AXI_CTRL, 32'h0, 4'hf, jtx_pkg::RESP_OK);
    dev_wr(jtx_pkg::REG_LINK, lctl);
    axi_wr(jtx_pkg::AXI_CTRL, 32'h1, 4'hf, jtx_pkg::RESP_OK);
    t = 0;
    do begin
      axi_rd(jtx_pkg::AXI_STATUS, d);
      t++;
    end while (d[2:1] != 2'd3 && t < 100);
    chk("status data", 32'h7, d);
    repeat (4) @(posedge clk);
  endtask
  task automatic watch(input int n);
    aa = 0;
    fc = 0;
    mf = 0;
    repeat (n) begin
      @(posedge clk);
      if (link_i.lane_k[0] === 1'b0 && link_i.lane_data[0] === 8'haa) aa++;
      if (link_i.lane_k[0] === 1'b1 && link_i.lane_data[0] === jtx_pkg::K_FR_END) fc++;
      if (link_i.lane_k[0] === 1'b1 && link_i.lane_data[0] === jtx_pkg::K_MF_END) mf++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
  initial begin
    logic [7:0] regs [4];
    logic [7:0] rst_v [4];
    logic [7:0] v;
    regs = '{jtx_pkg::REG_FRAME, jtx_pkg::REG_MFRAME, jtx_pkg::REG_LINK, jtx_pkg::REG_TEST};
    rst_v = '{jtx_pkg::FRAME_RST, jtx_pkg::MFRAME_RST, jtx_pkg::LINK_RST, jtx_pkg::TEST_RST};
    {awaddr, araddr, wstrb, wdata, smp} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    n_errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    axi_rd(jtx_pkg::AXI_STATUS, d);
    chk("status reset", 32'h0, d);
    for (int i = 0; i < 4; i++) begin
      dev_rd(regs[i], v);
      chk("device reset value", {24'h0, rst_v[i]}, {24'h0, v});
    end
    axi_wr(4'h2, 32'h0, 4'hf, jtx_pkg::RESP_ERR);
    $display("test reset values done");
    dev_wr(jtx_pkg::REG_TEST, 8'h81);
    dev_rd(jtx_pkg::REG_TEST, v);
    chk("test control", 32'h81, {24'h0, v});
    relink(8'h00);
    watch(20);
    chk("packed octets", 32'd10, aa);
    chk("frame markers", 32'd10, fc);
    $display("test fixed pattern done");
    relink(8'h02);
    watch(36);
    chk("multiframe markers", 32'd2, mf);
    chk("frame markers lsync", 32'd16, fc);
    $display("test lane sync done");
    relink(8'h01);  // Receiver end does not descramble
    watch(20);
    chk("scrambled", 32'd1, {31'h0, aa != 10});
    axi_wr(jtx_pkg::AXI_CTRL, 32'h0, 4'hf, jtx_pkg::RESP_OK);
    repeat (4) @(posedge clk);
    axi_rd(jtx_pkg::AXI_STATUS, d);
    chk("status held", 32'h0, d);
    chk("divider reset idle", 32'h0, {31'h0, divrst});
    $display("test scrambler done");
    give_verdict;
  end
endmodule
